// File: core/atc_top.sv
// converter control: channel routing, software and external start, trigger delay,
// done flag, interrupt and APB register slave
// assumes a converter core on pclk with a one-cycle start and a one-cycle done,
// pwm point pulses on pclk, and asynchronous pwm outputs and start pin
`include "atc_map.svh"

module atc_top
    import atc_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int ADC_DIV = `ATC_ADC_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] pwm_out_in,
    input wire logic ext_start_pin,
    input wire logic pwm_centre_pulse,
    input wire logic pwm_end_pulse,
    input wire logic conv_done_in,
    output logic conv_start,
    output logic [3:0] analog_channel_sel,
    output logic [8:0] ain_connect,
    output logic converter_power,
    output logic irq
);

    // byte addresses of the registers
    localparam logic [ADDR_W-1:0] A_CTRL2 = ADDR_W'({`ATC_IDX_CTRL2, 2'b00});
    localparam logic [ADDR_W-1:0] A_DLY_LO = ADDR_W'({`ATC_IDX_DLY_LO, 2'b00});
    localparam logic [ADDR_W-1:0] A_CTRL0 = ADDR_W'({`ATC_IDX_CTRL0, 2'b00});
    localparam logic [ADDR_W-1:0] A_CTRL1 = ADDR_W'({`ATC_IDX_CTRL1, 2'b00});
    localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'({`ATC_IDX_INT_STAT, 2'b00});
    localparam logic [ADDR_W-1:0] A_EN = ADDR_W'({`ATC_IDX_INT_EN, 2'b00});
    localparam logic [ADDR_W-1:0] A_CLR = ADDR_W'({`ATC_IDX_INT_CLR, 2'b00});
    localparam logic [7:0] DIV_LAST = 8'(ADC_DIV - 1);

    atc_ctrl_s ctrl_reg;
    atc_state_e state_reg;
    atc_state_e state_next;
    logic done_flag_reg;
    logic [1:0] int_stat_reg;
    logic [1:0] int_en_reg;
    logic [7:0] div_reg;
    logic adc_tick_reg;
    logic src_prev_reg;
    logic [3:0] pin_level;
    logic src_level;
    logic edge_rise;
    logic edge_fall;
    logic ext_hit;
    logic can_start;
    logic busy;
    logic wr_access;
    logic setup;
    logic byte0_wr;
    logic wr_ctrl0;
    logic sw_start;
    logic sw_done_clr;
    logic go_conv_now;
    logic go_delay;
    logic dly_expired;
    logic conv_complete;
    logic trig_dropped;
    logic [1:0] int_events;
    logic [1:0] int_clr;
    logic [1:0] int_stat_next;
    logic [7:0] rd_byte;
    logic rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and delay counter

    // pwm0, pwm2, pwm4 and start pin through three flip-flops and a registered agreement filter
    atc_sync3 #(
        .W(4)
    ) atc_sync3_i (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({ext_start_pin, pwm_out_in}),
        .level_out(pin_level)
    );

    // trigger delay in converter clock ticks
    atc_delay_cnt #(
        .W(9)
    ) atc_delay_cnt_i (
        .pclk(pclk),
        .presetn(presetn),
        .load(go_delay),
        .load_val(ctrl_reg.delay),
        .tick(adc_tick_reg),
        .abort(!ctrl_reg.enable),
        .expired(dly_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // setup phase and write strobe of the access phase
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;
    assign byte0_wr = wr_access && pstrb[0];
    assign wr_ctrl0 = byte0_wr && (paddr == A_CTRL0);
    assign sw_start = wr_ctrl0 && pwdata[`ATC_C0_START];
    assign sw_done_clr = wr_ctrl0 && !pwdata[`ATC_C0_DONE];
    assign int_clr = (byte0_wr && (paddr == A_CLR)) ? pwdata[1:0] : 2'b00;

    ////////////////////////////////////////////////////////////////////////////
    // trigger detection

    // selected source level from pwm channel or pin
    always_comb begin
        src_level = 1'b0;
        case (ctrl_reg.trig_src)
            `ATC_SRC_PWM0: src_level = pin_level[0];
            `ATC_SRC_PWM2: src_level = pin_level[1];
            `ATC_SRC_PWM4: src_level = pin_level[2];
            default: src_level = pin_level[3];
        endcase
    end

    // previous source level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= src_level;
        end
    end

    assign edge_rise = src_level && !src_prev_reg;
    assign edge_fall = !src_level && src_prev_reg;

    // trigger condition chosen by trigger type
    always_comb begin
        ext_hit = 1'b0;
        case (ctrl_reg.trig_type)
            `ATC_TYP_FALL: ext_hit = edge_fall;
            `ATC_TYP_RISE: ext_hit = edge_rise;
            `ATC_TYP_CENTRE: ext_hit = pwm_centre_pulse;
            default: ext_hit = pwm_end_pulse;
        endcase
        ext_hit = ext_hit && ctrl_reg.ext_en && ctrl_reg.enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter clock tick

    // tick divided from pclk, paces the trigger delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 8'h00;
            adc_tick_reg <= 1'b0;
        end else begin
            adc_tick_reg <= (div_reg == DIV_LAST);
            if (div_reg == DIV_LAST) begin
                div_reg <= 8'h00;
            end else begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer

    assign busy = (state_reg != ATC_ST_IDLE);
    assign can_start = !busy && !done_flag_reg && ctrl_reg.enable;
    assign go_conv_now = can_start && sw_start;
    assign go_delay = can_start && !sw_start && ext_hit;
    assign trig_dropped = ext_hit && !go_delay && !go_conv_now;
    assign conv_complete = (state_reg == ATC_ST_CONV) && conv_done_in;

    // next state from start requests, delay and core done
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ATC_ST_IDLE: begin
                if (go_conv_now) begin
                    state_next = ATC_ST_CONV;
                end else if (go_delay) begin
                    state_next = ATC_ST_DELAY;
                end
            end
            ATC_ST_DELAY: begin
                if (!ctrl_reg.enable) begin
                    state_next = ATC_ST_IDLE;
                end else if (dly_expired) begin
                    state_next = ATC_ST_CONV;
                end
            end
            ATC_ST_CONV: begin
                if (conv_complete) begin
                    state_next = ATC_ST_IDLE;
                end
            end
            default: state_next = ATC_ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ATC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // one-cycle start to the core on entry to conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= (state_next == ATC_ST_CONV) && (state_reg != ATC_ST_CONV);
        end
    end

    // done flag, completion wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_reg <= 1'b0;
        end else if (conv_complete) begin
            done_flag_reg <= 1'b1;
        end else if (sw_done_clr) begin
            done_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    // software writes to control and delay fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
        end else if (byte0_wr) begin
            if (paddr == A_DLY_LO) begin
                ctrl_reg.delay[7:0] <= pwdata[7:0];
            end else if (paddr == A_CTRL2) begin
                ctrl_reg.delay[8] <= pwdata[`ATC_C2_DLY8];
            end else if (paddr == A_CTRL0) begin
                ctrl_reg.trig_src <= pwdata[`ATC_C0_SRC_HI:`ATC_C0_SRC_LO];
                ctrl_reg.chan <= pwdata[`ATC_C0_CH_HI:`ATC_C0_CH_LO];
            end else if (paddr == A_CTRL1) begin
                ctrl_reg.trig_type <= pwdata[`ATC_C1_TYP_HI:`ATC_C1_TYP_LO];
                ctrl_reg.ext_en <= pwdata[`ATC_C1_EXT];
                ctrl_reg.enable <= pwdata[`ATC_C1_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog routing and power

    // one-hot input connection, none while disabled or reserved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ain_connect <= 9'h000;
            analog_channel_sel <= 4'h0;
            converter_power <= 1'b0;
        end else begin
            analog_channel_sel <= ctrl_reg.chan;
            converter_power <= ctrl_reg.enable;
            if (!ctrl_reg.enable) begin
                ain_connect <= 9'h000;
            end else if (ctrl_reg.chan <= `ATC_CH_BANDGAP) begin
                ain_connect <= 9'h001 << ctrl_reg.chan;
            end else begin
                ain_connect <= 9'h000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt

    assign int_events = {trig_dropped, conv_complete};
    assign int_stat_next = (int_stat_reg & ~int_clr) | int_events;

    // sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= 2'b00;
        end else begin
            int_stat_reg <= int_stat_next;
        end
    end

    // enable register and level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_reg <= 2'b00;
            irq <= 1'b0;
        end else begin
            if (byte0_wr && (paddr == A_EN)) begin
                int_en_reg <= pwdata[1:0];
            end
            irq <= |(int_stat_next & int_en_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux and bus answer

    // read value of the addressed register
    always_comb begin
        rd_byte = `ATC_RST_BYTE;
        rd_hit = 1'b1;
        if (paddr == A_DLY_LO) begin
            rd_byte = ctrl_reg.delay[7:0];
        end else if (paddr == A_CTRL2) begin
            rd_byte = {7'h00, ctrl_reg.delay[8]};
        end else if (paddr == A_CTRL0) begin
            rd_byte = {done_flag_reg, busy, ctrl_reg.trig_src, ctrl_reg.chan};
        end else if (paddr == A_CTRL1) begin
            rd_byte = {4'h0, ctrl_reg.trig_type, ctrl_reg.ext_en, ctrl_reg.enable};
        end else if (paddr == A_STAT) begin
            rd_byte = {6'h00, int_stat_reg};
        end else if (paddr == A_EN) begin
            rd_byte = {6'h00, int_en_reg};
        end else if (paddr == A_CLR) begin
            rd_byte = 8'h00;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // answer in the first access cycle, data caught in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !rd_hit;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

endmodule

// File: core/atc_map.svh
// register indices, field positions, reset values and codes of the converter control
// assumes a byte address of four times each index on the register bus
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// register indices, byte address is index times four
`define ATC_IDX_CTRL2 8'hE2
`define ATC_IDX_DLY_LO 8'hE3
`define ATC_IDX_CTRL0 8'hE8
`define ATC_IDX_CTRL1 8'hF3
`define ATC_IDX_INT_STAT 8'hF4
`define ATC_IDX_INT_EN 8'hF5
`define ATC_IDX_INT_CLR 8'hF6

// control zero fields
`define ATC_C0_DONE 7
`define ATC_C0_START 6
`define ATC_C0_SRC_HI 5
`define ATC_C0_SRC_LO 4
`define ATC_C0_CH_HI 3
`define ATC_C0_CH_LO 0

// control one fields
`define ATC_C1_TYP_HI 3
`define ATC_C1_TYP_LO 2
`define ATC_C1_EXT 1
`define ATC_C1_EN 0

// control two field
`define ATC_C2_DLY8 0

// interrupt status bits
`define ATC_INT_DONE 0
`define ATC_INT_DROP 1

// reset values
`define ATC_RST_BYTE 8'h00
`define ATC_RST_DLY 9'h000

// trigger types and sources
`define ATC_TYP_FALL 2'h0
`define ATC_TYP_RISE 2'h1
`define ATC_TYP_CENTRE 2'h2
`define ATC_TYP_END 2'h3
`define ATC_SRC_PWM0 2'h0
`define ATC_SRC_PWM2 2'h1
`define ATC_SRC_PWM4 2'h2
`define ATC_SRC_PIN 2'h3

// highest analog input code and band-gap code
`define ATC_CH_LAST_AIN 4'h7
`define ATC_CH_BANDGAP 4'h8

// converter clock as a division of pclk
`define ATC_ADC_DIV 4

`endif

// File: core/atc_pkg.sv
// types shared by the converter control files
// assumes nothing beyond the map header
package atc_pkg;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ATC_ST_IDLE = 3'b001,
        ATC_ST_DELAY = 3'b010,
        ATC_ST_CONV = 3'b100
    } atc_state_e;

    // software controlled configuration
    typedef struct packed {
        logic [8:0] delay;
        logic [1:0] trig_type;
        logic [1:0] trig_src;
        logic [3:0] chan;
        logic ext_en;
        logic enable;
    } atc_ctrl_s;

endpackage

// File: core/atc_sync3.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes pins are quiet for at least two pclk cycles between changes
module atc_sync3 #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // shift chain, first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // level follows only where second and third stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_out <= '0;
        end else begin
            level_out <= (s2_reg & s3_reg) | (level_out & (s2_reg ^ s3_reg));
        end
    end

endmodule

// File: core/atc_delay_cnt.sv
// down counter of converter clock ticks between trigger and conversion start
// assumes tick is a one-cycle pulse on pclk
module atc_delay_cnt #(
    parameter int W = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic tick,
    input wire logic abort,
    output logic expired
);

    logic [W-1:0] cnt_reg;
    logic running_reg;

    ////////////////////////////////////////////////////////////////////////////
    // count ticks, pulse expired once the count reaches zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            running_reg <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (abort) begin
                running_reg <= 1'b0;
            end else if (load) begin
                cnt_reg <= load_val;
                running_reg <= 1'b1;
            end else if (running_reg) begin
                if (cnt_reg == '0) begin
                    expired <= 1'b1;
                    running_reg <= 1'b0;
                end else if (tick) begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end

endmodule

// File: tb/atc_top_properties.sv
// concurrent checks on the ports of the converter control
// assumes one pclk domain and a bind onto every atc_top instance
module atc_top_properties #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_done_in,
    input wire logic conv_start,
    input wire logic [3:0] analog_channel_sel,
    input wire logic [8:0] ain_connect,
    input wire logic converter_power
);
    logic mapped;

    // decode of every register address
    assign mapped = paddr == 12'h388 || paddr == 12'h38C || paddr == 12'h3A0
        || paddr == 12'h3CC || paddr == 12'h3D0 || paddr == 12'h3D4 || paddr == 12'h3D8;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////////
    chk_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    chk_slverr_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    chk_slverr_alone: assert property (!pready |-> !pslverr)
        else $error("pslverr outside access");
    chk_rdata_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    chk_start_one_pulse: assert property (conv_start |=> !conv_start)
        else $error("conv_start longer than one cycle");
    chk_done_blocks_start: assert property (conv_done_in |=> !conv_start [*3])
        else $error("start right after completion");
    chk_start_needs_power: assert property (conv_start |-> converter_power)
        else $error("start while converter off");
    chk_ain_one_hot: assert property ($onehot0(ain_connect))
        else $error("more than one input connected");
    chk_power_off_open: assert property (!converter_power |-> ain_connect == 9'h000)
        else $error("input connected while off");
    chk_chan_route: assert property (converter_power && analog_channel_sel <= 4'h8
        |-> ain_connect == (9'h001 << analog_channel_sel))
        else $error("wrong input connected");
endmodule

////////////////////////////////////////////////////////////////////////////////
bind atc_top atc_top_properties #(.ADDR_W(ADDR_W)) atc_top_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done_in(conv_done_in), .conv_start(conv_start),
    .analog_channel_sel(analog_channel_sel), .ain_connect(ain_connect),
    .converter_power(converter_power));

// File: tb/atc_core_model.sv
// behavioural analog converter core answering start with done
// assumes lat is steady while a conversion runs
module atc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire logic [7:0] lat,
    output logic conv_done_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // one-cycle done pulse lat+2 cycles after start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            conv_done_in <= 1'b0;
        end else begin
            conv_done_in <= cnt == 1;
            if (conv_start) begin
                cnt <= lat + 1;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// File: tb/atc_top_test.sv
// self-checking bench of the converter control over APB
// assumes the bound checker and the core model beside the design
module atc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 2;
    localparam logic [11:0] A_C2 = 12'h388, A_DLY = 12'h38C, A_C0 = 12'h3A0, A_C1 = 12'h3CC;
    localparam logic [11:0] A_ST = 12'h3D0, A_EN = 12'h3D4, A_CLR = 12'h3D8;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h3DE5;
    logic [3:0] pstrb = 4'h0, analog_channel_sel;
    logic [2:0] pwm_out_in = 3'h0;
    logic ext_start_pin = 1'b0, pwm_centre_pulse = 1'b0, pwm_end_pulse = 1'b0;
    logic pready, pslverr, conv_done_in, conv_start, converter_power, irq, e;
    logic [8:0] ain_connect;
    logic [7:0] lat = 8'h04;
    logic [11:0] regs [7] = '{A_C2, A_DLY, A_C0, A_C1, A_ST, A_EN, A_CLR};
    int err_count = 0, compares = 0, cycles = 0, n;

    atc_top #(.ADDR_W(12), .ADC_DIV(DIV)) atc_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out_in(pwm_out_in), .ext_start_pin(ext_start_pin),
        .pwm_centre_pulse(pwm_centre_pulse), .pwm_end_pulse(pwm_end_pulse),
        .conv_done_in(conv_done_in), .conv_start(conv_start),
        .analog_channel_sel(analog_channel_sel), .ain_connect(ain_connect),
        .converter_power(converter_power), .irq(irq));
    atc_core_model atc_core_model_i (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .lat(lat), .conv_done_in(conv_done_in));

    always #2 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            conclude();
        end
    end

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [31:0] exp_ain(input int c, input bit en);
        return (!en || c > 8) ? 32'h0 : 32'h1 << c;
    endfunction

    task conclude();
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            $display("wrong value %s expected %h seen %h", nm, ex, got);
            err_count++;
        end
    endtask

    // one apb transfer, held until pready at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(nm, ex, rdat);
    endtask

    // cycles until conv_start is seen, at most lim
    task wstart(input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (conv_start !== 1'b1 && n < lim);
    endtask

    // selected trigger event when right, otherwise the other pwm point pulse or a toggle of every unselected source
    task fire(input int s, input int t, input bit right);
        if (t >= 2) begin
            pwm_centre_pulse <= (t == 2) == right;
            pwm_end_pulse <= (t == 3) == right;
            @(posedge pclk);
            {pwm_centre_pulse, pwm_end_pulse} <= 2'b00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if ((i == s) == right && i < 3) pwm_out_in[i] <= ~pwm_out_in[i];
                if ((i == s) == right && i == 3) ext_start_pin <= ~ext_start_pin;
            end
        end
    endtask

    task ext_case(input int s, input int t);
        logic [8:0] d;
        logic [31:0] r;
        r = xs();
        d = (s + t == 0) ? 9'h000 : (s + t == 6) ? 9'h1FF : {3'b000, r[5:0]};
        lat <= {3'b000, r[12:8]};
        {pwm_out_in, ext_start_pin} <= {4{t == 0}};
        wr(A_DLY, {24'h0, d[7:0]});
        wr(A_C2, {31'h0, d[8]});
        wr(A_C0, s << 4);
        wr(A_C1, t << 2 | 3);
        fire(s, t, 1'b0);
        wstart(12);
        chk("unselected trigger", 0, conv_start === 1'b1);
        rd(A_C0, s << 4, "idle after unselected trigger");
        fire(s, t, 1'b1);
        wstart(1500);
        chk("trigger delay", 1, n >= d * DIV + 1 && n <= d * DIV + DIV + 9);
        repeat (lat + 4) @(posedge pclk);
        rd(A_C0, 32'h80 | s << 4, "done after trigger");
        wr(A_C0, s << 4);
        wr(A_C1, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i], 0, "reset value");
        end
        rd(12'h3A4, 0, "unmapped read");
        chk("unmapped error", 1, e);
        wr(12'h3A8, 32'hFF);
        chk("unmapped write error", 1, e);
        // channel routing with the converter on, then off
        wr(A_C1, 1);
        for (int c = 0; c < 16; c++) begin
            wr(A_C0, c);
            repeat (2) @(posedge pclk);
            chk("ain_connect", exp_ain(c, 1'b1), ain_connect);
            chk("channel", c, analog_channel_sel);
        end
        wr(A_C0, xs() & 32'h7);
        wr(A_C1, 0);
        repeat (2) @(posedge pclk);
        chk("ain_connect off", 0, ain_connect);
        chk("power off", 0, converter_power);
        wr(A_C1, 1);
        wr(A_C0, 0);
        wstart(20);
        chk("start on zero write", 0, conv_start === 1'b1);
        apb(1'b1, A_C0, 32'h40, 4'hE);
        wstart(20);
        chk("start without strobe", 0, conv_start === 1'b1);
        // software start with a long delay armed and a pin edge while busy
        wr(A_EN, 1);
        wr(A_DLY, 32'hFF);
        wr(A_C2, 1);
        wr(A_C1, 32'h7);
        lat <= 8'h28;
        wr(A_C0, 32'h70);
        wstart(5);
        chk("software start latency", 1, n);
        rd(A_C0, 32'h70, "busy bit");
        ext_start_pin <= 1'b1;
        wstart(12);
        chk("trigger while busy", 0, conv_start === 1'b1);
        repeat (44) @(posedge pclk);
        rd(A_C0, 32'hB0, "done flag");
        rd(A_ST, 3, "status");
        chk("irq raised", 1, irq);
        wr(A_EN, 0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 0, irq);
        wr(A_EN, 1);
        wr(A_C0, 32'hF0);
        wstart(20);
        chk("start with done set", 0, conv_start === 1'b1);
        wr(A_C0, 32'h30);
        rd(A_C0, 32'h30, "done cleared");
        wr(A_CLR, 3);
        rd(A_ST, 0, "status cleared");
        chk("irq cleared", 0, irq);
        // pin trigger into a long delay, then converter off aborts it
        ext_start_pin <= 1'b0;
        wr(A_C1, 32'h7);
        repeat (6) @(posedge pclk);
        ext_start_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(A_C0, 32'h70, "busy in delay");
        wr(A_C1, 32'h6);
        rd(A_C0, 32'h30, "delay aborted");
        wr(A_C1, 1);
        // every source with every trigger type
        for (int s = 0; s < 4; s++) begin
            for (int t = 0; t < 4; t++) ext_case(s, t);
        end
        conclude();
    end
endmodule
